// >>> bench/lsw_host_model.sv
// Host model that issues register writes and reads to the control block.
`timescale 1ns/100ps
module lsw_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Strobes idle low from time zero.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One write, taken at the rising edge inside the strobe; idle lines show inverted data.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // One read; the registered answer is settled by the next falling edge.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : lsw_host_model

// >>> bench/testbench.sv
// Self-checking bench for the load switch control register bank.
`timescale 1ns/100ps
module testbench;
  logic clk;
  logic srst;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [4:0] pins;
  logic s1, s2, m1, m2, so1, so2, d1, d2;
  logic [1:0] l1, l2;
  logic [4:0] v1, v2;
  int err_total = 0;
  int n_tests = 0;
  logic [7:0] ra [7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0c, 8'h0d};
  logic [7:0] rm [7] = '{8'h0f, 8'h0f, 8'hff, 8'h01, 8'h01, 8'h1f, 8'h1f};
  lsw_ctrl uut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .control_input_pins(pins), .switch1_on(s1), .switch2_on(s2), .switch1_mode(m1),
    .switch2_mode(m2), .switch1_softstart_off(so1), .switch2_softstart_off(so2),
    .switch1_softstart_level(l1), .switch2_softstart_level(l2),
    .switch1_discharge_on(d1), .switch2_discharge_on(d2),
    .regulator1_voltage_code(v1), .regulator2_voltage_code(v2));
  lsw_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compares one value and counts the result.
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Reads one register and compares it.
  task rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rc
  // Moves one pin and waits past the synchroniser and edge detector.
  task pe(input int i, input logic v);
    @(negedge clk);
    pins[i] = v;
    repeat (5) @(negedge clk);
  endtask : pe
  // Prints the counts and the verdict, then stops.
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // Watchdog cuts a hang short well beyond the expected run time.
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
  // Main sequence.
  initial begin
    srst = 1'b1;
    pins = 5'h00;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 14; i++) rc(8'(i), 8'h00);
    chk({6'h00, s2, s1}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      host.wr(ra[i], 8'hff);
      rc(ra[i], rm[i]);
    end
    host.wr(8'h04, 8'hff);
    rc(8'h04, 8'h00);
    chk({m2, m1, 1'b0, v1}, 8'hdf);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h07, 8'(i * 20));
      chk({d2, d1, l2, l1, so2, so1}, 8'(i * 20));
    end
    host.wr(8'h07, 8'hb6);
    chk({d2, d1, l2, l1, so2, so1}, 8'hb6);
    host.wr(8'h0d, 8'h17);
    chk({3'h0, v2}, 8'h17);
    host.wr(8'h08, 8'h00);
    host.wr(8'h09, 8'h00);
    host.wr(8'h05, 8'h00);
    host.wr(8'h06, 8'h00);
    $display("test registers done");
    host.wr(8'h00, 8'h00);
    rc(8'h04, 8'h00);
    host.wr(8'h00, 8'h01);
    rc(8'h04, 8'h11);
    host.wr(8'h08, 8'h01);
    rc(8'h04, 8'h12);
    host.wr(8'h02, 8'h01);
    rc(8'h04, 8'h16);
    host.wr(8'h01, 8'h00);
    rc(8'h04, 8'h16);
    host.wr(8'h01, 8'h01);
    rc(8'h04, 8'h14);
    host.wr(8'h03, 8'h01);
    rc(8'h04, 8'h00);
    host.wr(8'h08, 8'h00);
    $display("test tasks done");
    host.wr(8'h05, 8'h01);
    host.wr(8'h06, 8'h01);
    repeat (2) @(negedge clk);
    pe(0, 1'b1);
    chk({6'h00, s2, s1}, 8'h03);
    pe(0, 1'b0);
    chk({6'h00, s2, s1}, 8'h00);
    host.wr(8'h05, 8'h06);
    for (int c = 1; c < 6; c++) begin
      host.wr(8'h06, 8'(c));
      repeat (2) @(negedge clk);
      pe(c - 1, 1'b1);
      chk({6'h00, s2, s1}, 8'h02);
      pe(c - 1, 1'b0);
      chk({6'h00, s2, s1}, 8'h00);
    end
    host.wr(8'h06, 8'h07);
    pe(0, 1'b1);
    chk({6'h00, s2, s1}, 8'h00);
    pe(0, 1'b0);
    host.wr(8'h05, 8'h0b);
    repeat (2) @(negedge clk);
    pe(2, 1'b1);
    chk({6'h00, s2, s1}, 8'h00);
    pe(2, 1'b0);
    chk({6'h00, s2, s1}, 8'h01);
    $display("test pins done");
    host.wr(8'h06, 8'h01);
    pe(0, 1'b1);
    chk({6'h00, s2, s1}, 8'h03);
    @(negedge clk);
    pins[0] = 1'b0;
    @(negedge clk);
    host.wr(8'h02, 8'h01);
    chk({6'h00, s2, s1}, 8'h01);
    $display("test priority done");
    complete_run();
  end
endmodule : testbench

// >>> hdl/lsw_consts.svh
// Constants for the load switch and regulator control block.
`ifndef LSW_CONSTS_SVH
`define LSW_CONSTS_SVH
// ****************************************************************************
// Register offsets.
// ****************************************************************************
`define LSW_OFF_SW1_EN_TASK 8'h00
`define LSW_OFF_SW1_DIS_TASK 8'h01
`define LSW_OFF_SW2_EN_TASK 8'h02
`define LSW_OFF_SW2_DIS_TASK 8'h03
`define LSW_OFF_STATUS 8'h04
`define LSW_OFF_SW1_PIN_SEL 8'h05
`define LSW_OFF_SW2_PIN_SEL 8'h06
`define LSW_OFF_CFG 8'h07
`define LSW_OFF_SW1_MODE 8'h08
`define LSW_OFF_SW2_MODE 8'h09
`define LSW_OFF_REG1_VOUT 8'h0c
`define LSW_OFF_REG2_VOUT 8'h0d
// ****************************************************************************
// Field positions, codes and reset values.
// ****************************************************************************
`define LSW_SEL_LSB 0
`define LSW_SEL_MSB 2
`define LSW_INV_BIT 3
`define LSW_SEL_FIRST 3'h1
`define LSW_SEL_LAST 3'h5
`define LSW_SS_OFF1_BIT 0
`define LSW_SS_OFF2_BIT 1
`define LSW_SS_LVL1_LSB 2
`define LSW_SS_LVL2_LSB 4
`define LSW_DIS1_BIT 6
`define LSW_DIS2_BIT 7
`define LSW_VOUT_MSB 4
`define LSW_NUM_PINS 5
`define LSW_RESET_BYTE 8'h00
`endif

// >>> hdl/lsw_ctrl.sv
// Register bank and enable control for two load switches with regulator mode.
`timescale 1ns/100ps
`include "lsw_consts.svh"
module lsw_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [`LSW_NUM_PINS-1:0] control_input_pins,
  output logic switch1_on,
  output logic switch2_on,
  output logic switch1_mode,
  output logic switch2_mode,
  output logic switch1_softstart_off,
  output logic switch2_softstart_off,
  output logic [1:0] switch1_softstart_level,
  output logic [1:0] switch2_softstart_level,
  output logic switch1_discharge_on,
  output logic switch2_discharge_on,
  output logic [4:0] regulator1_voltage_code,
  output logic [4:0] regulator2_voltage_code
);
  // ****************************************************************************
  // State.
  // ****************************************************************************
  typedef struct packed {
    logic [3:0] pin_sel1;   // Switch 1 select and invert.
    logic [3:0] pin_sel2;   // Switch 2 select and invert.
    logic [7:0] cfg;        // Soft start and discharge configuration.
    logic mode1;            // Switch 1 mode select.
    logic mode2;            // Switch 2 mode select.
    logic [4:0] vout1;      // Regulator 1 voltage code.
    logic [4:0] vout2;      // Regulator 2 voltage code.
    logic [1:0] en;         // Held enable state per switch.
    logic [1:0] ctl_prev;   // Previous control level per switch.
    logic [1:0] ctl_valid;  // Previous level holds a real sample.
    logic [7:0] rdata;      // Read data.
  } lsw_state_type;
  lsw_state_type s_reg;
  lsw_state_type s_next;
  lsw_pkg::lsw_access_type acc;      // Decoded host access.
  logic [`LSW_NUM_PINS-1:0] pins_s;  // Synchronised pins.
  logic [1:0] set_req;               // One-cycle enable requests.
  logic [1:0] clr_req;               // One-cycle disable requests.
  logic [1:0] ctl_lvl;               // Current control level per switch.
  logic [1:0] ctl_act;               // Switch has a pin assigned.
  logic [7:0] status;                // Status byte.
  // ****************************************************************************
  // Pin synchroniser.
  // ****************************************************************************
  lsw_pin_sync u_sync (
    .clk(clk),
    .srst(srst),
    .pin_async(control_input_pins),
    .pin_sync(pins_s)
  );
  // Classify the host access; a write takes precedence.
  always_comb begin
    if (reg_wr) begin
      acc = lsw_pkg::LSW_ACC_WRITE;
    end else if (reg_rd) begin
      acc = lsw_pkg::LSW_ACC_READ;
    end else begin
      acc = lsw_pkg::LSW_ACC_IDLE;
    end
  end
  // Pick each switch's pin, apply invert, and tell whether one is assigned.
  always_comb begin
    logic [3:0] sel;
    sel = '0;
    for (int i = 0; i < 2; i++) begin
      sel = (i == 0) ? s_reg.pin_sel1 : s_reg.pin_sel2;
      ctl_act[i] = (sel[2:0] >= `LSW_SEL_FIRST) && (sel[2:0] <= `LSW_SEL_LAST);
      ctl_lvl[i] = 1'b0;
      if (ctl_act[i]) begin
        ctl_lvl[i] = pins_s[sel[2:0] - `LSW_SEL_FIRST] ^ sel[`LSW_INV_BIT];
      end
    end
  end
  // Build one-cycle requests from task writes and pin edges.
  always_comb begin
    logic wr;
    wr = (acc == lsw_pkg::LSW_ACC_WRITE) && reg_wdata[0];
    set_req[0] = wr && (reg_addr == `LSW_OFF_SW1_EN_TASK);
    clr_req[0] = wr && (reg_addr == `LSW_OFF_SW1_DIS_TASK);
    set_req[1] = wr && (reg_addr == `LSW_OFF_SW2_EN_TASK);
    clr_req[1] = wr && (reg_addr == `LSW_OFF_SW2_DIS_TASK);
    for (int i = 0; i < 2; i++) begin
      if (ctl_act[i] && s_reg.ctl_valid[i]) begin
        set_req[i] = set_req[i] | (ctl_lvl[i] & ~s_reg.ctl_prev[i]);
        clr_req[i] = clr_req[i] | (~ctl_lvl[i] & s_reg.ctl_prev[i]);
      end
    end
  end
  // Assemble the status byte from mode and enable.
  always_comb begin
    status = '0;
    status[0] = s_reg.en[0] & ~s_reg.mode1;
    status[1] = s_reg.en[0] & s_reg.mode1;
    status[2] = s_reg.en[1] & ~s_reg.mode2;
    status[3] = s_reg.en[1] & s_reg.mode2;
    status[4] = |s_reg.en;
  end
  // Next-state logic: register writes, enable update and read data.
  always_comb begin
    s_next = s_reg;
    for (int i = 0; i < 2; i++) begin
      if (clr_req[i]) begin
        s_next.en[i] = 1'b0;
      end else if (set_req[i]) begin
        s_next.en[i] = 1'b1;
      end
    end
    s_next.ctl_prev = ctl_lvl;
    s_next.ctl_valid = ctl_act;
    // A rewritten selection starts a fresh history, so the old pin's level
    // cannot fake an edge on the newly chosen pin.
    if (acc == lsw_pkg::LSW_ACC_WRITE && reg_addr == `LSW_OFF_SW1_PIN_SEL) begin
      s_next.ctl_valid[0] = 1'b0;
    end
    if (acc == lsw_pkg::LSW_ACC_WRITE && reg_addr == `LSW_OFF_SW2_PIN_SEL) begin
      s_next.ctl_valid[1] = 1'b0;
    end
    if (acc == lsw_pkg::LSW_ACC_WRITE) begin
      if (reg_addr == `LSW_OFF_SW1_PIN_SEL) begin
        s_next.pin_sel1 = reg_wdata[3:0];
      end else if (reg_addr == `LSW_OFF_SW2_PIN_SEL) begin
        s_next.pin_sel2 = reg_wdata[3:0];
      end else if (reg_addr == `LSW_OFF_CFG) begin
        s_next.cfg = reg_wdata;
      end else if (reg_addr == `LSW_OFF_SW1_MODE) begin
        s_next.mode1 = reg_wdata[0];
      end else if (reg_addr == `LSW_OFF_SW2_MODE) begin
        s_next.mode2 = reg_wdata[0];
      end else if (reg_addr == `LSW_OFF_REG1_VOUT) begin
        s_next.vout1 = reg_wdata[`LSW_VOUT_MSB:0];
      end else if (reg_addr == `LSW_OFF_REG2_VOUT) begin
        s_next.vout2 = reg_wdata[`LSW_VOUT_MSB:0];
      end
    end
    if (acc == lsw_pkg::LSW_ACC_READ) begin
      if (reg_addr == `LSW_OFF_STATUS) begin
        s_next.rdata = status;
      end else if (reg_addr == `LSW_OFF_SW1_PIN_SEL) begin
        s_next.rdata = {4'h0, s_reg.pin_sel1};
      end else if (reg_addr == `LSW_OFF_SW2_PIN_SEL) begin
        s_next.rdata = {4'h0, s_reg.pin_sel2};
      end else if (reg_addr == `LSW_OFF_CFG) begin
        s_next.rdata = s_reg.cfg;
      end else if (reg_addr == `LSW_OFF_SW1_MODE) begin
        s_next.rdata = {7'h00, s_reg.mode1};
      end else if (reg_addr == `LSW_OFF_SW2_MODE) begin
        s_next.rdata = {7'h00, s_reg.mode2};
      end else if (reg_addr == `LSW_OFF_REG1_VOUT) begin
        s_next.rdata = {3'h0, s_reg.vout1};
      end else if (reg_addr == `LSW_OFF_REG2_VOUT) begin
        s_next.rdata = {3'h0, s_reg.vout2};
      end else begin
        s_next.rdata = 8'h00;
      end
    end
  end
  // Register the whole state; everything resets to zero, switches off.
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  // ****************************************************************************
  // Outputs straight from flip-flops.
  // ****************************************************************************
  assign reg_rdata = s_reg.rdata;
  assign switch1_on = s_reg.en[0];
  assign switch2_on = s_reg.en[1];
  assign switch1_mode = s_reg.mode1;
  assign switch2_mode = s_reg.mode2;
  assign switch1_softstart_off = s_reg.cfg[`LSW_SS_OFF1_BIT];
  assign switch2_softstart_off = s_reg.cfg[`LSW_SS_OFF2_BIT];
  assign switch1_softstart_level = s_reg.cfg[`LSW_SS_LVL1_LSB +: 2];
  assign switch2_softstart_level = s_reg.cfg[`LSW_SS_LVL2_LSB +: 2];
  assign switch1_discharge_on = s_reg.cfg[`LSW_DIS1_BIT];
  assign switch2_discharge_on = s_reg.cfg[`LSW_DIS2_BIT];
  assign regulator1_voltage_code = s_reg.vout1;
  assign regulator2_voltage_code = s_reg.vout2;
  // ****************************************************************************
  // Checks.
  // ****************************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // A set task counts only when no pin falling edge hits the same switch.
  sequence task_en1_seq;
    reg_wr && reg_addr == `LSW_OFF_SW1_EN_TASK && reg_wdata[0]
      && !(ctl_act[0] && s_reg.ctl_valid[0] && !ctl_lvl[0] && s_reg.ctl_prev[0]);
  endsequence
  // The same for the set task of switch 2.
  sequence task_en2_seq;
    reg_wr && reg_addr == `LSW_OFF_SW2_EN_TASK && reg_wdata[0]
      && !(ctl_act[1] && s_reg.ctl_valid[1] && !ctl_lvl[1] && s_reg.ctl_prev[1]);
  endsequence
  // Both switches follow pin 0 without invert, and neither selection just moved.
  sequence both_on_pin0_seq;
    s_reg.pin_sel1 == 4'h1 && s_reg.pin_sel2 == 4'h1 && $stable(s_reg.pin_sel1)
      && $stable(s_reg.pin_sel2) && s_reg.ctl_valid == 2'b11;
  endsequence
  // The synchronised pin 0 rises while the host writes nothing.
  sequence pin0_rise_seq;
    $rose(pins_s[0]) && !reg_wr;
  endsequence
  // Right after reset both switches are off and the read data is clear.
  AST_RESET_OFF: assert property (
    $past(srst) |-> !switch1_on && !switch2_on && reg_rdata == 8'h00)
    else $error("Switch on after reset.");
  // A set task turns its switch on in the next cycle.
  AST_EN1_TASK: assert property (task_en1_seq |=> switch1_on)
    else $error("Enable task 1 failed.");
  AST_EN2_TASK: assert property (task_en2_seq |=> switch2_on)
    else $error("Enable task 2 failed.");
  // A clear task turns its switch off in the next cycle.
  AST_DIS1_TASK: assert property (
    reg_wr && reg_addr == `LSW_OFF_SW1_DIS_TASK && reg_wdata[0] |=> !switch1_on)
    else $error("Disable task 1 failed.");
  AST_DIS2_TASK: assert property (
    reg_wr && reg_addr == `LSW_OFF_SW2_DIS_TASK && reg_wdata[0] |=> !switch2_on)
    else $error("Disable task 2 failed.");
  // A zero written to a clear task leaves the switch alone when no pin edge is due.
  AST_ZERO_NOP: assert property (
    reg_wr && reg_addr == `LSW_OFF_SW1_DIS_TASK && !reg_wdata[0]
    && !(ctl_act[0] && s_reg.ctl_valid[0] && ctl_lvl[0] != s_reg.ctl_prev[0])
    |=> $stable(switch1_on)) else $error("Zero write acted.");
  // A status read returns the enable state split by mode, one cycle later.
  AST_STATUS: assert property (
    reg_rd && !reg_wr && reg_addr == `LSW_OFF_STATUS
    |=> reg_rdata == {3'h0, $past(switch1_on | switch2_on),
    $past(switch2_on & switch2_mode), $past(switch2_on & !switch2_mode),
    $past(switch1_on & switch1_mode), $past(switch1_on & !switch1_mode)})
    else $error("Bad status.");
  // Task registers read back as zero.
  AST_TASK_READ0: assert property (
    reg_rd && !reg_wr && reg_addr <= `LSW_OFF_SW2_DIS_TASK |=> reg_rdata == 8'h00)
    else $error("Task read nonzero.");
  // A clear request beats a set request in the same cycle.
  AST_PRIO: assert property (set_req[1] && clr_req[1] |=> !switch2_on)
    else $error("Enable beat disable.");
  // A rising level on an assigned pin turns the switch on.
  AST_PIN_RISE: assert property (
    ctl_act[0] && s_reg.ctl_valid[0] && ctl_lvl[0] && !s_reg.ctl_prev[0] && !clr_req[0]
    |=> switch1_on) else $error("Pin edge ignored.");
  // A falling level on an assigned pin turns the switch off.
  AST_PIN_FALL: assert property (
    ctl_act[1] && s_reg.ctl_valid[1] && !ctl_lvl[1] && s_reg.ctl_prev[1]
    |=> !switch2_on) else $error("Pin fall ignored.");
  // One pin edge shared by both switches turns both on together.
  AST_SHARED_PIN: assert property (
    both_on_pin0_seq ##0 pin0_rise_seq |=> switch1_on && switch2_on)
    else $error("Shared pin edge missed.");
  // With invert set, a falling pin 2 counts as a rising control level.
  AST_INVERT1: assert property (
    s_reg.pin_sel1 == 4'hb && $stable(s_reg.pin_sel1) && s_reg.ctl_valid[0]
    && $fell(pins_s[2]) && !reg_wr |=> switch1_on) else $error("Invert ignored.");
  // An unused select code leaves the switch to the task registers alone.
  AST_NOPIN1: assert property (
    (s_reg.pin_sel1[2:0] == 3'h0 || s_reg.pin_sel1[2:0] > `LSW_SEL_LAST) && !reg_wr
    |=> $stable(switch1_on)) else $error("Unused code moved switch 1.");
  AST_NOPIN2: assert property (
    (s_reg.pin_sel2[2:0] == 3'h0 || s_reg.pin_sel2[2:0] > `LSW_SEL_LAST) && !reg_wr
    |=> $stable(switch2_on)) else $error("Unused code moved switch 2.");
  // Configuration, mode and voltage writes show on the outputs one cycle later.
  AST_CFG_WR: assert property (
    reg_wr && reg_addr == `LSW_OFF_CFG
    |=> {switch2_discharge_on, switch1_discharge_on, switch2_softstart_level,
    switch1_softstart_level, switch2_softstart_off, switch1_softstart_off}
    == $past(reg_wdata)) else $error("Configuration write lost.");
  AST_MODE_WR: assert property (
    reg_wr && reg_addr == `LSW_OFF_SW2_MODE |=> switch2_mode == $past(reg_wdata[0]))
    else $error("Mode write lost.");
  AST_VOUT1_WR: assert property (
    reg_wr && reg_addr == `LSW_OFF_REG1_VOUT
    |=> regulator1_voltage_code == $past(reg_wdata[`LSW_VOUT_MSB:0]))
    else $error("Voltage 1 write lost.");
  AST_VOUT2_WR: assert property (
    reg_wr && reg_addr == `LSW_OFF_REG2_VOUT
    |=> regulator2_voltage_code == $past(reg_wdata[`LSW_VOUT_MSB:0]))
    else $error("Voltage 2 write lost.");
endmodule : lsw_ctrl

// >>> hdl/lsw_pin_sync.sv
// Two-stage synchroniser for the control input pins.
`timescale 1ns/100ps
`include "lsw_consts.svh"
module lsw_pin_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`LSW_NUM_PINS-1:0] pin_async,
  output logic [`LSW_NUM_PINS-1:0] pin_sync
);
  // ****************************************************************************
  // State.
  // ****************************************************************************
  typedef struct packed {
    logic [`LSW_NUM_PINS-1:0] stage1; // First stage, read only by the second.
    logic [`LSW_NUM_PINS-1:0] stage2; // Second stage, safe for logic.
  } lsw_sync_type;
  lsw_sync_type s_reg;
  lsw_sync_type s_next;
  // Shift the pins through both stages.
  always_comb begin
    s_next.stage1 = pin_async;
    s_next.stage2 = s_reg.stage1;
  end
  // Register the stages; reset to low.
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign pin_sync = s_reg.stage2;
endmodule : lsw_pin_sync

// >>> hdl/lsw_pkg.sv
// Types shared by the load switch and regulator control block.
package lsw_pkg;
  // Host access kind seen by the register port.
  typedef enum logic [1:0] {LSW_ACC_IDLE, LSW_ACC_WRITE, LSW_ACC_READ} lsw_access_type;
endpackage : lsw_pkg
